/* src/ecd_defines.svh */
/*
 * Constants of the embedded-clock deserializer: register offsets, field
 * positions, reset values and frame figures.
 * Assumes inclusion by bare name from the package and the top module.
 */
`ifndef ECD_DEFINES_SVH
`define ECD_DEFINES_SVH

// Frame layout: start bit, 10 payload bits, stop bit
`define ECD_PAYLOAD_BITS    10
`define ECD_FRAME_BITS      12

// Register byte offsets
`define ECD_OFS_CTRL        8'h00
`define ECD_OFS_STATUS      8'h04
`define ECD_OFS_DATA        8'h08

// Control register fields and reset values
`define ECD_CTRL_OE_BIT     0
`define ECD_CTRL_SLEEPN_BIT 1
`define ECD_CTRL_EDGE_BIT   2
`define ECD_CTRL_RESET      3'h7

// Status register fields
`define ECD_ST_LOCKN_BIT    0
`define ECD_ST_AMBIG_BIT    1
`define ECD_ST_REFOK_BIT    2
`define ECD_ST_SLEEP_BIT    3

// Timing counts, in clock cycles or events
`define ECD_BIT_CYCLES      8
`define ECD_REF_LOCK_EDGES  16
`define ECD_LOCK_WORDS      4

`endif

/* src/ecd_pkg.sv */
/*
 * Types of the embedded-clock deserializer.
 * Assumes ecd_defines.svh is on the include path.
 */
`include "ecd_defines.svh"

package ecd_pkg;

   // Receive sequencing states
   typedef enum logic [1:0] {
      ECD_REF_ACQ,
      ECD_HUNT,
      ECD_LOCKED,
      ECD_SLEEP
   } ecd_state_t;

   // Software control bits
   typedef struct packed {
      logic edge_sel;
      logic sleep_n;
      logic rx_oe;
   } ecd_ctrl_t;

   // Recovered word with its pin drive
   typedef struct packed {
      logic [`ECD_PAYLOAD_BITS-1:0] word;
      logic                         word_oe;
      logic                         rclk;
   } ecd_out_t;

endpackage : ecd_pkg

/* src/ecd_deserializer.sv */
/*
 * Receive side of a 10-bit embedded-clock serial link with an APB slave.
 * Assumes serial_line and reference_clock are asynchronous pins, a
 * matching serializer at the far end, and an APB master on clock.
 */
// The implementer's own choices: the register addresses and the APB slave port.
// Functional notes
// R1 - Serial stream becomes 10-bit words on parallel_out with recovered clock.
// R2 - After power-up, outputs float and logic idles until reference acquired.
// R3 - System supplies a free-running reference_clock the device acquires first.
// R4 - Transmitter training pattern is six ones then six zeros per word.
// R5 - link_acquired_n stays high throughout acquisition.
// R6 - Lock is possible on random data; training locks within bounded time.
// R7 - Transmitter trains while either training request is high.
// R8 - On edges, lock to clock bits, then drive link_acquired_n low, show data.
// R9 - Transmitter samples parallel_in on edge chosen by tx_edge_select.
// R10 - Transmitter ignores parallel_in after 5 word clocks of training request.
// R11 - Each word has start bit 1 and stop bit 0 as clock reference.
// R12 - Word on line is 10 payload plus 2 framing bits.
// R13 - Transmitter drives only when enabled, awake and not training; the serializer model also drives the line with the training pattern.
// R14 - parallel_out is valid only while link_acquired_n is low.
// R15 - parallel_out is timed to recovered_clock_out, polarity from edge select.
// R16 - Losing lock raises link_acquired_n and floats data and clock outputs.
// R17 - System should request training when link_acquired_n rises.
// R18 - Data presented on rising clock edge if edge select high, else falling.
// R19 - Output enable low floats data and clock; lock flag stays driven.
// R20 - Sleep and output enable both low stops acquisition; waking relocks.
// R21 - Several candidate clock positions keep link_acquired_n inactive.
`timescale 1ns/1ps
`include "ecd_defines.svh"

module ecd_deserializer
   import ecd_pkg::*;
#(
   parameter int BIT_CYCLES     = `ECD_BIT_CYCLES,
   parameter int REF_LOCK_EDGES = `ECD_REF_LOCK_EDGES,
   parameter int LOCK_WORDS     = `ECD_LOCK_WORDS
) (
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic        reference_clock,
   input  wire logic        serial_line,
   output logic [9:0]       parallel_out,
   output logic             parallel_out_oe,
   output logic             recovered_clock_out,
   output logic             recovered_clock_oe,
   output logic             link_acquired_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);

   localparam int FB = `ECD_FRAME_BITS;
   localparam int PB = `ECD_PAYLOAD_BITS;
   localparam logic [7:0] HALF_BIT = 8'(BIT_CYCLES / 2);
   localparam logic [7:0] LAST_BIT = 8'(BIT_CYCLES - 1);
   localparam logic [7:0] REF_EDGES = 8'(REF_LOCK_EDGES);
   localparam logic [7:0] LOCK_WDS = 8'(LOCK_WORDS);

   // Count of set bits in the candidate mask
   function automatic logic [3:0] ecd_count(input logic [FB-1:0] m);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < FB; i++) begin
         n = n + 4'(m[i]);
      end
      return n;
   endfunction : ecd_count

   // Position of the lowest set bit in the candidate mask
   function automatic logic [3:0] ecd_first(input logic [FB-1:0] m);
      logic [3:0] p;
      p = 4'h0;
      for (int i = FB - 1; i >= 0; i--) begin
         if (m[i]) begin
            p = 4'(i);
         end
      end
      return p;
   endfunction : ecd_first

   // Two-flop synchronisers, plus a history flop for edge detection
   logic ser_meta, ser_sync, ser_prev;
   logic ref_meta, ref_sync, ref_prev;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ser_meta <= 1'b0;
         ser_sync <= 1'b0;
         ser_prev <= 1'b0;
         ref_meta <= 1'b0;
         ref_sync <= 1'b0;
         ref_prev <= 1'b0;
      end else begin
         ser_meta <= serial_line;
         ser_sync <= ser_meta;
         ser_prev <= ser_sync;
         ref_meta <= reference_clock;
         ref_sync <= ref_meta;
         ref_prev <= ref_sync;
      end
   end

   ecd_ctrl_t ctrl;
   ecd_state_t state, next_state;
   logic [7:0] bit_cnt, next_bit_cnt;
   logic [7:0] ref_cnt, next_ref_cnt;
   logic [7:0] word_cnt, next_word_cnt;
   logic [3:0] fill, next_fill;
   logic [3:0] phase, next_phase;
   logic [3:0] lock_ph, next_lock_ph;
   logic [FB-1:0] shreg, next_shreg;
   logic [FB-1:0] cand, next_cand;
   logic ambig, next_ambig;
   logic lock_n, next_lock_n;
   ecd_out_t outs, next_outs;
   logic [FB-1:0] sh_new;
   logic [3:0] ph_inc, ph_mid, n_cand;
   logic sample, ser_edge, ref_rise, frame_ok, drive, sleep_req;

   // Link sequencing: bit timing, lock hunt, word capture and output drive
   always_comb begin
      next_state    = state;
      next_bit_cnt  = bit_cnt;
      next_ref_cnt  = ref_cnt;
      next_word_cnt = word_cnt;
      next_fill     = fill;
      next_phase    = phase;
      next_lock_ph  = lock_ph;
      next_shreg    = shreg;
      next_cand     = cand;
      next_ambig    = ambig;
      next_lock_n   = 1'b1;
      next_outs     = outs;
      ser_edge  = ser_sync ^ ser_prev;
      ref_rise  = ref_sync & ~ref_prev;
      sleep_req = ~ctrl.sleep_n & ~ctrl.rx_oe;
      sample    = (bit_cnt == HALF_BIT) & ~ser_edge;
      sh_new    = {shreg[FB-2:0], ser_sync};
      frame_ok  = sh_new[FB-1] & ~sh_new[0];                 // R11
      ph_inc    = (phase == 4'(FB - 1)) ? 4'h0 : phase + 4'h1;  // R12
      ph_mid    = (lock_ph >= 4'(FB / 2)) ? lock_ph - 4'(FB / 2) : lock_ph + 4'(FB / 2);
      n_cand    = ecd_count(cand);
      // Bit timer realigns to every line edge
      if (ser_edge || bit_cnt == LAST_BIT) begin
         next_bit_cnt = 8'h00;
      end else begin
         next_bit_cnt = bit_cnt + 8'h01;
      end
      if (sample) begin
         next_shreg = sh_new;
         next_phase = ph_inc;
      end
      case (state)
         ECD_REF_ACQ: begin
            // Hold lock hunt and outputs idle until the reference has run for a while
            if (ref_rise) begin                              // R2 R3
               next_ref_cnt = ref_cnt + 8'h01;
            end
            if (ref_cnt >= REF_EDGES) begin
               next_state    = ECD_HUNT;
               next_cand     = '1;
               next_fill     = 4'h0;
               next_word_cnt = 8'h00;
               next_ambig    = 1'b0;
            end
         end
         ECD_HUNT: begin
            // Drop every phase where no start-after-stop boundary is seen
            if (sample) begin                                // R6 R8
               if (fill != 4'(FB)) begin
                  next_fill = fill + 4'h1;
               end else if (!frame_ok) begin
                  next_cand[phase] = 1'b0;
               end
               if (fill == 4'(FB) && phase == 4'(FB - 1)) begin
                  next_word_cnt = (word_cnt == 8'hFF) ? word_cnt : word_cnt + 8'h01;
               end
            end
            if (n_cand == 4'h0) begin
               next_cand     = '1;
               next_word_cnt = 8'h00;
               next_ambig    = 1'b0;
            end else if (word_cnt >= LOCK_WDS) begin
               if (n_cand == 4'h1) begin                     // R8
                  next_state   = ECD_LOCKED;
                  next_lock_ph = ecd_first(cand);
                  next_ambig   = 1'b0;
                  // Idle level first, so the first word comes with an active edge
                  next_outs.rclk = ~ctrl.edge_sel;           // R18
               end else begin
                  next_ambig = 1'b1;                         // R21
               end
            end
         end
         ECD_LOCKED: begin
            next_lock_n = 1'b0;                              // R8
            if (sample && phase == lock_ph) begin
               if (frame_ok) begin
                  // Payload lies between start and stop, first bit oldest
                  for (int i = 0; i < PB; i++) begin         // R1
                     next_outs.word[i] = sh_new[PB - i];
                  end
                  next_outs.rclk = ctrl.edge_sel;            // R15 R18
               end else begin
                  next_state    = ECD_HUNT;                  // R16
                  next_lock_n   = 1'b1;
                  next_cand     = '1;
                  next_fill     = 4'h0;
                  next_word_cnt = 8'h00;
               end
            end else if (sample && phase == ph_mid) begin
               next_outs.rclk = ~ctrl.edge_sel;              // R18
            end
         end
         default: begin
            // Asleep: acquisition stopped until sleep_n rises
            if (ctrl.sleep_n) begin                          // R20
               next_state   = ECD_REF_ACQ;
               next_ref_cnt = 8'h00;
            end
         end
      endcase
      if (sleep_req) begin                                   // R20
         next_state   = ECD_SLEEP;
         next_lock_n  = 1'b1;
         next_ref_cnt = 8'h00;
      end
      // Pins float whenever lock is absent or software disables them
      drive = ~next_lock_n & ctrl.rx_oe;                     // R14 R16 R19
      next_outs.word_oe = drive;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state    <= ECD_REF_ACQ;
         bit_cnt  <= 8'h00;
         ref_cnt  <= 8'h00;
         word_cnt <= 8'h00;
         fill     <= 4'h0;
         phase    <= 4'h0;
         lock_ph  <= 4'h0;
         shreg    <= '0;
         cand     <= '1;
         ambig    <= 1'b0;
         lock_n   <= 1'b1;                                   // R5
         outs     <= '0;
      end else begin
         state    <= next_state;
         bit_cnt  <= next_bit_cnt;
         ref_cnt  <= next_ref_cnt;
         word_cnt <= next_word_cnt;
         fill     <= next_fill;
         phase    <= next_phase;
         lock_ph  <= next_lock_ph;
         shreg    <= next_shreg;
         cand     <= next_cand;
         ambig    <= next_ambig;
         lock_n   <= next_lock_n;                            // R5
         outs     <= next_outs;
      end
   end

   assign parallel_out        = outs.word;
   assign parallel_out_oe     = outs.word_oe;
   assign recovered_clock_out = outs.rclk;
   assign recovered_clock_oe  = outs.word_oe;
   assign link_acquired_n     = lock_n;

   // APB slave: no wait states, answer registered from the setup cycle
   ecd_ctrl_t next_ctrl;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr, setup, wr_take, hit;
   always_comb begin
      next_ctrl    = ctrl;
      next_prdata  = prdata;
      next_pslverr = 1'b0;
      setup        = psel & ~penable;
      wr_take      = psel & penable & pready & pwrite;
      next_pready  = setup;
      hit          = 1'b1;
      if (setup) begin
         next_prdata = 32'h0000_0000;
         if (paddr == `ECD_OFS_CTRL) begin
            next_prdata[2:0] = ctrl;
         end else if (paddr == `ECD_OFS_STATUS) begin
            next_prdata[`ECD_ST_LOCKN_BIT]  = lock_n;
            next_prdata[`ECD_ST_AMBIG_BIT]  = ambig;
            next_prdata[`ECD_ST_REFOK_BIT]  = (state == ECD_HUNT) | (state == ECD_LOCKED);
            next_prdata[`ECD_ST_SLEEP_BIT]  = (state == ECD_SLEEP);
         end else if (paddr == `ECD_OFS_DATA) begin
            next_prdata[PB-1:0] = outs.word;
         end else begin
            hit = 1'b0;
         end
         next_pslverr = ~hit;
      end
      if (wr_take && paddr == `ECD_OFS_CTRL) begin
         next_ctrl.rx_oe    = pwdata[`ECD_CTRL_OE_BIT];
         next_ctrl.sleep_n  = pwdata[`ECD_CTRL_SLEEPN_BIT];
         next_ctrl.edge_sel = pwdata[`ECD_CTRL_EDGE_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ctrl    <= `ECD_CTRL_RESET;
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ctrl    <= next_ctrl;
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

endmodule : ecd_deserializer

/* verification/ecd_serializer_model.sv */
/* Behavioural far-end serializer: framed words or the training pattern.
   Assumes the bench drives its controls and carries serial_line on. */
`timescale 1ns/1ps
module ecd_serializer_model
   import ecd_pkg::*;
(
   output logic            serial_line,
   input  wire logic [9:0] parallel_in,
   input  wire logic       training_request_a,
   input  wire logic       training_request_b,
   input  wire logic       driver_enable_tx,
   input  wire logic       tx_edge_select,
   input  wire logic       bad_stop
);
   logic [11:0] frame;
   logic [9:0]  held;
   int          i;
   // Start bit goes first; each bit lasts 400 ns
   initial begin
      serial_line = 1'b0;
      held = 10'h000;
      #11;
      forever begin
         // Word clock rises at frame start and falls half a frame later
         if (tx_edge_select) begin
            held = parallel_in;
         end
         if (training_request_a || training_request_b) begin
            frame = 12'h03F;
         end else begin
            frame = {bad_stop, held, 1'b1};
         end
         for (i = 0; i < 12; i++) begin
            if (i == 6 && !tx_edge_select) begin
               held = parallel_in;
            end
            // A released line toggles, so no stale level shows
            serial_line = driver_enable_tx ? frame[i] : ~serial_line;
            #400;
         end
      end
   end
endmodule : ecd_serializer_model

/* verification/ecd_deserializer_checker.sv */
/* Port checker for the deserializer.
   Assumes binding to ecd_deserializer; one clock domain. */
`timescale 1ns/1ps
`include "ecd_defines.svh"
module ecd_deserializer_checker
   import ecd_pkg::*;
(
   input wire logic        clock,
   input wire logic        sys_rst,
   input wire logic        reference_clock,
   input wire logic        serial_line,
   input wire logic [9:0]  parallel_out,
   input wire logic        parallel_out_oe,
   input wire logic        recovered_clock_out,
   input wire logic        recovered_clock_oe,
   input wire logic        link_acquired_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   // Bus phases
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   property p_apb_answer;
      s_setup |=> s_access;
   endproperty
   property p_ready_pulse;
      pready |-> penable ##1 !pready;
   endproperty
   property p_err_unmapped;
      s_setup and (paddr != `ECD_OFS_CTRL && paddr != `ECD_OFS_STATUS
         && paddr != `ECD_OFS_DATA) |=> pslverr && pready;
   endproperty
   property p_oe_pair;
      parallel_out_oe == recovered_clock_oe;
   endproperty
   property p_valid_locked;
      parallel_out_oe |-> !link_acquired_n;
   endproperty
   property p_acquire_high;
      $fell(sys_rst) |-> link_acquired_n [*8];
   endproperty
   property p_reset_float;
      $fell(sys_rst) |-> !parallel_out_oe && parallel_out == 10'h000;
   endproperty
   property p_word_clock;
      $changed(parallel_out) && parallel_out_oe && $past(parallel_out_oe)
         |-> $changed(recovered_clock_out);
   endproperty
   a_apb_answer:   assert property (p_apb_answer) else $error("no ready after setup");
   a_ready_pulse:  assert property (p_ready_pulse) else $error("ready not a pulse");
   a_err_unmapped: assert property (p_err_unmapped) else $error("no slave error");
   a_oe_pair:      assert property (p_oe_pair) else $error("enables differ");
   a_valid_locked: assert property (p_valid_locked) else $error("driven unlocked");
   a_acquire_high: assert property (p_acquire_high) else $error("early lock");
   a_reset_float:  assert property (p_reset_float) else $error("driven in reset");
   a_word_clock:   assert property (p_word_clock) else $error("word off clock");
endmodule : ecd_deserializer_checker

bind ecd_deserializer ecd_deserializer_checker ecd_deserializer_checker_inst (
   .clock(clock), .sys_rst(sys_rst), .reference_clock(reference_clock),
   .serial_line(serial_line), .parallel_out(parallel_out),
   .parallel_out_oe(parallel_out_oe), .recovered_clock_out(recovered_clock_out),
   .recovered_clock_oe(recovered_clock_oe), .link_acquired_n(link_acquired_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* verification/embedded_clock_deserializer_test.sv */
/* Self-checking bench for the deserializer with a serializer model.
   Assumes the bound checker and a 400 ns link bit and reference clock. */
`timescale 1ns/1ps
module embedded_clock_deserializer_test;
   import ecd_pkg::*;
   logic clock = 1'b0, sys_rst = 1'b1, reference_clock = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic [9:0] parallel_in = 10'h002, parallel_out;
   logic tr_a = 1'b0, tr_b = 1'b0, bad_stop = 1'b0, tx_edge = 1'b1, serial_line;
   logic parallel_out_oe, recovered_clock_out, recovered_clock_oe;
   logic link_acquired_n, pready, pslverr;
   int n_errors = 0, comparisons = 0, cycles = 0;
   localparam int LOCK_CYCLES = (12 + 12 * 2) * 8;
   ecd_deserializer #(.BIT_CYCLES(8), .REF_LOCK_EDGES(2), .LOCK_WORDS(2))
      ecd_deserializer_inst (.clock(clock), .sys_rst(sys_rst),
      .reference_clock(reference_clock), .serial_line(serial_line),
      .parallel_out(parallel_out), .parallel_out_oe(parallel_out_oe),
      .recovered_clock_out(recovered_clock_out), .recovered_clock_oe(recovered_clock_oe),
      .link_acquired_n(link_acquired_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   ecd_serializer_model ecd_serializer_model_inst (.serial_line(serial_line),
      .parallel_in(parallel_in), .training_request_a(tr_a), .training_request_b(tr_b),
      .driver_enable_tx(1'b1), .tx_edge_select(tx_edge), .bad_stop(bad_stop));
   // System clock and a free-running reference of unrelated phase
   always #25 clock = ~clock;
   initial begin
      #7;
      forever #200 reference_clock = ~reference_clock;
   end
   // Cut a hang short
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_errors++;
         test_done();
      end
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check
   // One APB transfer; read data and error taken at the ready edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      // No count limit: only pready or the bench timeout ends this wait
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_link(input logic lvl);
      int n;
      n = 0;
      while (link_acquired_n !== lvl && n < 4000) begin
         @(posedge clock);
         n++;
      end
      check("link_acquired_n", lvl, link_acquired_n);
   endtask : wait_link
   task automatic send_word(input logic [9:0] w, input logic edge_lvl);
      int n;
      parallel_in <= w;
      n = 0;
      while (parallel_out !== w && n < 400) begin
         @(posedge clock);
         n++;
      end
      check("parallel_out", w, parallel_out);
      check("recovered_clock_out", edge_lvl, recovered_clock_out);
      check("parallel_out_oe", 1'b1, parallel_out_oe);
   endtask : send_word
   task automatic test_reset;
      check("link_acquired_n", 1'b1, link_acquired_n);
      check("recovered_clock_oe", 1'b0, recovered_clock_oe);
      apb(1'b0, 8'h00, 32'h0);
      check("ctrl", 32'h7, rd);
      apb(1'b1, 8'h04, 32'hFFFFFFFE);
      check("pslverr", 1'b0, err);
      apb(1'b0, 8'h04, 32'h0);
      check("status lock", 1'b1, rd[0]);
      apb(1'b0, 8'h0C, 32'h0);
      check("pslverr", 1'b1, err);
      $display("test_reset done");
   endtask : test_reset
   task automatic test_ambiguous;
      repeat (3 * LOCK_CYCLES) @(posedge clock);
      check("link_acquired_n", 1'b1, link_acquired_n);
      apb(1'b0, 8'h04, 32'h0);
      check("status ambiguous", 1'b1, rd[1]);
      check("status ref", 1'b1, rd[2]);
      parallel_in <= 10'h3FF;
      wait_link(1'b0);
      send_word(10'h2A5, 1'b1);
      apb(1'b0, 8'h08, 32'h0);
      check("data", 32'h2A5, rd);
      $display("test_ambiguous done");
   endtask : test_ambiguous
   task automatic test_unlock;
      bad_stop <= 1'b1;
      wait_link(1'b1);
      check("parallel_out_oe", 1'b0, parallel_out_oe);
      bad_stop <= 1'b0;
      tr_b <= 1'b1;
      wait_link(1'b0);
      tr_b <= 1'b0;
      send_word(10'h0F0, 1'b1);
      $display("test_unlock done");
   endtask : test_unlock
   task automatic test_sleep;
      apb(1'b1, 8'h00, 32'h6);
      repeat (3) @(posedge clock);
      check("parallel_out_oe", 1'b0, parallel_out_oe);
      check("link_acquired_n", 1'b0, link_acquired_n);
      apb(1'b0, 8'h00, 32'h0);
      check("ctrl", 32'h6, rd);
      apb(1'b1, 8'h00, 32'h4);
      wait_link(1'b1);
      apb(1'b0, 8'h04, 32'h0);
      check("status asleep", 1'b1, rd[3]);
      check("status ref", 1'b0, rd[2]);
      tr_a <= 1'b1;
      tx_edge <= 1'b0;
      apb(1'b1, 8'h00, 32'h3);
      wait_link(1'b0);
      tr_a <= 1'b0;
      send_word(10'h1C3, 1'b0);
      $display("test_sleep done");
   endtask : test_sleep
   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done
   // Main sequence
   initial begin
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      test_reset();
      test_ambiguous();
      test_unlock();
      test_sleep();
      test_done();
   end
endmodule : embedded_clock_deserializer_test
